// ==== hw/icap_pkg.sv ====
// Overview of operation
// R1: Registers reached only by system-register instructions; no memory-mapped path exists.
// R2: Three register classes: physical, virtual, and hypervisor virtual control.
// R3: Virtual class accessible only when executing at Non-secure EL1.
// R4: Hypervisor configuration routing selects physical or virtual register at EL1.
// R5: Group-0 active priorities: 5 priority bits, 32 levels, one bit each.
// R6: Bit n set means an interrupt is active at priority n times eight.
// R7: Active-priorities registers reset to all zeros.
// R8: Group-0 register is one copy shared by Secure and Non-secure states.
// R9: Separate group-1 active-priorities register with the same layout.
// R10: 32-bit and 64-bit views share storage; writes visible through both.
// R11: Bit index is the upper five bits of the 8-bit priority.
package icap_pkg;

    localparam int unsigned PRIO_BITS = 5;
    localparam int unsigned LEVELS = 32;
    localparam int unsigned IDX_LSB = 3;
    localparam logic [31:0] AP_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ICAP_CLS_PHYS,
        ICAP_CLS_VIRT,
        ICAP_CLS_VCTRL
    } icap_class_type;

    typedef enum logic [1:0] {
        ICAP_EL0,
        ICAP_EL1,
        ICAP_EL2,
        ICAP_EL3
    } icap_el_type;

    typedef enum logic {
        ICAP_GRP0,
        ICAP_GRP1
    } icap_grp_type;

    // One system-register access; wide64 marks the 64-bit execution-state view
    typedef struct packed {
        logic valid;
        logic write;
        icap_class_type cls;
        icap_grp_type grp;
        icap_el_type el;
        logic nonsecure;
        logic wide64;
        logic [31:0] wdata;
    } icap_req_type;

    typedef struct packed {
        logic ack;
        logic denied;
        logic [31:0] rdata;
    } icap_rsp_type;

    // Activate/deactivate event from the priority logic
    typedef struct packed {
        logic valid;
        logic activate;
        icap_grp_type grp;
        logic [7:0] prio;
    } icap_evt_type;

endpackage : icap_pkg

// ==== hw/icap_bitmap.sv ====
`timescale 1ns/1ps
`default_nettype none
// One active-priorities bitmap; register write, then event update per bit
module icap_bitmap (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register write
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    // Event
    input wire logic evt_en,
    input wire logic evt_set,
    input wire logic [4:0] evt_idx,
    // State
    output logic [31:0] bits_r
);
    genvar gi;
    generate
        for (gi = 0; gi < icap_pkg::LEVELS; gi++)
        begin : g_lvl
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    bits_r[gi] <= icap_pkg::AP_RESET[gi]; // [R7]
                else if (evt_en && evt_idx == 5'(gi))
                    bits_r[gi] <= evt_set; // [R6]
                else if (wr_en)
                    bits_r[gi] <= wr_data[gi]; // [R5]
            end
        end
    endgenerate
endmodule : icap_bitmap
`default_nettype wire

// ==== hw/icap_cpu_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// CPU interface active-priority registers, reached only over the sysreg port
module icap_cpu_if (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // System-register access port, the sole path to the registers
    input wire icap_pkg::icap_req_type req,
    output icap_pkg::icap_rsp_type rsp,
    // Hypervisor configuration routing bits
    input wire logic hcr_route_fiq,
    input wire logic hcr_route_irq,
    // Activation events
    input wire icap_pkg::icap_evt_type phys_evt,
    input wire icap_pkg::icap_evt_type virt_evt,
    // State
    output logic [31:0] phys_ap0,
    output logic [31:0] phys_ap1,
    output logic [31:0] virt_ap0,
    output logic [31:0] virt_ap1
);
    logic at_ns_el1;
    logic routed_virt;
    logic virt_ok;
    icap_pkg::icap_class_type eff_cls;
    logic allowed;
    logic [3:0] wr_sel;
    logic [3:0] ev_sel;
    logic [4:0] pidx;
    logic [4:0] vidx;
    logic [31:0] rd_mux;
    icap_pkg::icap_rsp_type rsp_r;
    logic [31:0] store [4];

    assign at_ns_el1 = req.nonsecure && req.el == icap_pkg::ICAP_EL1;
    // Group 0 rides the FIQ route, group 1 the IRQ route
    assign routed_virt = (req.grp == icap_pkg::ICAP_GRP0) ? hcr_route_fiq : hcr_route_irq;

    always_comb
    begin
        eff_cls = req.cls;
        if (req.cls == icap_pkg::ICAP_CLS_PHYS && at_ns_el1 && routed_virt)
            eff_cls = icap_pkg::ICAP_CLS_VIRT; // [R4]
    end

    assign virt_ok = at_ns_el1; // [R3]
    always_comb
    begin
        if (eff_cls == icap_pkg::ICAP_CLS_VIRT)
            allowed = virt_ok; // [R3]
        else if (eff_cls == icap_pkg::ICAP_CLS_VCTRL)
            allowed = req.el == icap_pkg::ICAP_EL2 || req.el == icap_pkg::ICAP_EL3;
        else
            allowed = req.el != icap_pkg::ICAP_EL0;
    end

    // Slot 0/1 physical, 2/3 virtual; control class aliases the virtual slots [R2]
    always_comb
    begin
        wr_sel = 4'h0;
        if (req.valid && req.write && allowed)
        begin
            if (eff_cls == icap_pkg::ICAP_CLS_PHYS)
                wr_sel[{1'b0, req.grp}] = 1'b1; // [R8]
            else
                wr_sel[{1'b1, req.grp}] = 1'b1; // [R2]
        end
    end

    assign pidx = phys_evt.prio[7:icap_pkg::IDX_LSB]; // [R11]
    assign vidx = virt_evt.prio[7:icap_pkg::IDX_LSB]; // [R11]
    assign ev_sel = {virt_evt.valid && virt_evt.grp == icap_pkg::ICAP_GRP1,
                     virt_evt.valid && virt_evt.grp == icap_pkg::ICAP_GRP0,
                     phys_evt.valid && phys_evt.grp == icap_pkg::ICAP_GRP1,
                     phys_evt.valid && phys_evt.grp == icap_pkg::ICAP_GRP0};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_reg
            // Both execution-state views address the same storage [R10]
            icap_bitmap u_bm (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .wr_en(wr_sel[gi]),
                .wr_data(req.wdata),
                .evt_en(ev_sel[gi]),
                .evt_set(gi < 2 ? phys_evt.activate : virt_evt.activate),
                .evt_idx(gi < 2 ? pidx : vidx),
                .bits_r(store[gi])
            ); // [R9]
        end
    endgenerate

    assign phys_ap0 = store[0];
    assign phys_ap1 = store[1];
    assign virt_ap0 = store[2];
    assign virt_ap1 = store[3];

    always_comb
    begin
        if (eff_cls == icap_pkg::ICAP_CLS_PHYS)
            rd_mux = store[{1'b0, req.grp}];
        else
            rd_mux = store[{1'b1, req.grp}];
    end

    // Denied accesses read zero and do not write; trap signalling is upstream
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rsp_r <= '0;
        else
        begin
            rsp_r.ack <= req.valid;
            rsp_r.denied <= req.valid && !allowed;
            rsp_r.rdata <= (req.valid && !req.write && allowed) ? rd_mux : 32'h0000_0000;
        end
    end
    assign rsp = rsp_r; // [R1]

    // Class gating
    a_virt_gate: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R3]
        req.valid && req.cls == icap_pkg::ICAP_CLS_VIRT && !at_ns_el1 |=> rsp.denied && rsp.rdata == 32'h0)
        else $error("virtual access outside NS EL1 not denied");
    a_ctrl_gate: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R2]
        req.valid && req.cls == icap_pkg::ICAP_CLS_VCTRL && !req.el[1] |=> rsp.denied && rsp.rdata == 32'h0)
        else $error("control class reached below EL2");
    a_el0_refused: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R3]
        req.valid && req.el == icap_pkg::ICAP_EL0 |=> rsp.denied)
        else $error("EL0 access not denied");
    a_denied_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R3]
        req.valid && req.write && !allowed && !phys_evt.valid && !virt_evt.valid
        |=> $stable(phys_ap0) && $stable(phys_ap1) && $stable(virt_ap0) && $stable(virt_ap1))
        else $error("denied write changed a bitmap");

    // Routing: each group follows its own route bit, and only at NS EL1
    a_route_virt: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R4]
        req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_PHYS && at_ns_el1
        && req.grp == icap_pkg::ICAP_GRP0 && hcr_route_fiq && !phys_evt.valid && !virt_evt.valid
        |=> virt_ap0 == $past(req.wdata) && $stable(phys_ap0))
        else $error("routed write did not reach virtual copy");
    a_route_irq: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R4]
        req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_PHYS && at_ns_el1
        && req.grp == icap_pkg::ICAP_GRP1 && hcr_route_irq && !phys_evt.valid && !virt_evt.valid
        |=> virt_ap1 == $past(req.wdata) && $stable(phys_ap1))
        else $error("routed group 1 write did not reach virtual copy");
    a_route_clear: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R4]
        req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_PHYS && at_ns_el1
        && req.grp == icap_pkg::ICAP_GRP0 && !hcr_route_fiq && !phys_evt.valid
        |=> phys_ap0 == $past(req.wdata))
        else $error("unrouted write did not reach physical copy");
    a_phys_keeps_virt: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R4]
        req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_PHYS && !at_ns_el1 && !virt_evt.valid
        |=> $stable(virt_ap0) && $stable(virt_ap1))
        else $error("physical write outside NS EL1 changed virtual state");
    a_virt_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R2]
        req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_VIRT && at_ns_el1
        && req.grp == icap_pkg::ICAP_GRP0 && !virt_evt.valid
        |=> virt_ap0 == $past(req.wdata))
        else $error("virtual write lost");

    // Storage and views
    a_phys_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R9]
        req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_PHYS && req.el == icap_pkg::ICAP_EL3
        && req.grp == icap_pkg::ICAP_GRP1 && !phys_evt.valid |=> phys_ap1 == $past(req.wdata))
        else $error("group 1 write lost");
    a_shared_views: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R10]
        req.valid && req.write && allowed && req.wide64 && eff_cls == icap_pkg::ICAP_CLS_PHYS
        && req.grp == icap_pkg::ICAP_GRP0 && !phys_evt.valid
        ##1 req.valid && !req.write && !req.wide64 && allowed && eff_cls == icap_pkg::ICAP_CLS_PHYS
        && req.grp == icap_pkg::ICAP_GRP0 && !phys_evt.valid
        |=> rsp.rdata == $past(req.wdata, 2))
        else $error("32-bit view does not see 64-bit write");
    a_single_copy: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R8]
        req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_PHYS && req.grp == icap_pkg::ICAP_GRP0
        && req.el == icap_pkg::ICAP_EL3 && !phys_evt.valid |=> phys_ap0 == $past(req.wdata))
        else $error("secure write not in shared group 0 copy");
    a_ns_shared: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R8]
        req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_PHYS && req.grp == icap_pkg::ICAP_GRP0
        && req.nonsecure && req.el == icap_pkg::ICAP_EL2 && !phys_evt.valid |=> phys_ap0 == $past(req.wdata))
        else $error("non-secure write not in shared group 0 copy");
    a_read_data: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R8]
        req.valid && !req.write && req.cls == icap_pkg::ICAP_CLS_PHYS && req.el == icap_pkg::ICAP_EL3
        && req.grp == icap_pkg::ICAP_GRP0 |=> rsp.rdata == $past(phys_ap0))
        else $error("read data differs from group 0 state");
    a_write_rdata: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R2]
        req.valid && req.write |=> rsp.rdata == 32'h0)
        else $error("write returned read data");

    // Events; the low three priority bits must not move the level
    a_evt_bit: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R6]
        phys_evt.valid && phys_evt.activate && phys_evt.grp == icap_pkg::ICAP_GRP0
        |=> phys_ap0[$past(phys_evt.prio[7:3])])
        else $error("activation did not set bit prio/8");
    a_evt_one_bit: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R6]
        phys_evt.valid && phys_evt.grp == icap_pkg::ICAP_GRP0 && !(req.valid && req.write)
        |=> ((phys_ap0 ^ $past(phys_ap0)) & ~(32'h0000_0001 << $past(phys_evt.prio[7:3]))) == 32'h0)
        else $error("event touched other priority levels");
    a_virt_evt: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R6]
        virt_evt.valid && virt_evt.activate && virt_evt.grp == icap_pkg::ICAP_GRP1
        |=> virt_ap1[$past(virt_evt.prio[7:3])])
        else $error("virtual activation did not set its bit");
    a_evt_clear: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R11]
        phys_evt.valid && !phys_evt.activate && phys_evt.grp == icap_pkg::ICAP_GRP1
        |=> !phys_ap1[$past(phys_evt.prio[7:3])])
        else $error("deactivation did not clear bit");
    a_low_bits: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R11]
        phys_evt.valid && phys_evt.activate && phys_evt.grp == icap_pkg::ICAP_GRP0
        && phys_evt.prio == 8'h07 |=> phys_ap0[0])
        else $error("low priority bits moved the level");
    a_bit_width: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R5]
        phys_evt.valid && phys_evt.activate && phys_evt.grp == icap_pkg::ICAP_GRP0
        && phys_evt.prio == 8'hf8 |=> phys_ap0[31])
        else $error("top level not in bit 31");

    // Reset and response
    a_reset_zero: assert property (@(posedge clk_sys) // [R7]
        $past(sys_rst) |-> phys_ap0 == 32'h0 && phys_ap1 == 32'h0 && virt_ap0 == 32'h0)
        else $error("active priorities not zero after reset");
    a_reset_rsp: assert property (@(posedge clk_sys) // [R7]
        $past(sys_rst) |-> rsp == '0 && virt_ap1 == 32'h0)
        else $error("response or virtual group 1 not clear after reset");
    a_ack_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R1]
        !req.valid |=> !rsp.ack)
        else $error("spurious ack");
    a_ack_follow: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R1]
        req.valid |=> rsp.ack)
        else $error("access not acknowledged");
    a_ctrl_alias: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R2]
        req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_VCTRL && req.el == icap_pkg::ICAP_EL2
        && req.grp == icap_pkg::ICAP_GRP1 && !virt_evt.valid |=> virt_ap1 == $past(req.wdata))
        else $error("control class write missed virtual state");

    c_virt_write: cover property (@(posedge clk_sys) req.valid && req.write && eff_cls == icap_pkg::ICAP_CLS_VIRT && allowed);
    c_denied: cover property (@(posedge clk_sys) req.valid && !allowed);
    c_activate: cover property (@(posedge clk_sys) phys_evt.valid && phys_evt.activate ##1 phys_evt.valid && !phys_evt.activate);
    c_routed_write: cover property (@(posedge clk_sys) req.valid && req.write && req.cls == icap_pkg::ICAP_CLS_PHYS
        && eff_cls == icap_pkg::ICAP_CLS_VIRT);
    c_shared_read: cover property (@(posedge clk_sys) req.valid && req.write && req.wide64
        ##1 req.valid && !req.write && !req.wide64);
endmodule : icap_cpu_if
`default_nettype wire

// ==== sim/icap_dist_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Distributor stand-in: forwards each commanded event to one side only
module icap_dist_model (
    // Command from the bench
    input wire icap_pkg::icap_evt_type cmd,
    input wire logic to_virt,
    // Events towards the interface
    output wire icap_pkg::icap_evt_type phys_evt,
    output wire icap_pkg::icap_evt_type virt_evt
);
    // The unused side gets an idle event, never a stale copy
    assign phys_evt = to_virt ? '0 : cmd;
    assign virt_evt = to_virt ? cmd : '0;
endmodule : icap_dist_model
`default_nettype wire

// ==== sim/irq_cpu_if_active_priority_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_cpu_if_active_priority_bench;
    localparam int CYCLE_LIMIT = 5000;
    logic clk_sys;
    logic sys_rst = 1'b1;
    logic [1:0] route = 2'b00;
    logic ev_virt = 1'b0;
    icap_pkg::icap_req_type req = '0;
    icap_pkg::icap_evt_type ev_cmd = '0;
    icap_pkg::icap_rsp_type rsp;
    icap_pkg::icap_evt_type phys_evt;
    icap_pkg::icap_evt_type virt_evt;
    icap_pkg::icap_req_type r;
    icap_pkg::icap_evt_type e;
    logic [31:0] ap [4];
    logic [31:0] exp_ap [4] = '{default: '0};
    // Outputs trail the drive by two edges, so keep two expectations
    logic [33:0] e_rsp [2] = '{default: '0};
    logic [31:0] e_ap [2][4] = '{default: '{default: '0}};
    logic [31:0] seed = 32'hdf03a4f6;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    icap_cpu_if u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rsp(rsp),
        .hcr_route_fiq(route[0]), .hcr_route_irq(route[1]), .phys_evt(phys_evt), .virt_evt(virt_evt),
        .phys_ap0(ap[0]), .phys_ap1(ap[1]), .virt_ap0(ap[2]), .virt_ap1(ap[3]));
    icap_dist_model u_dist (.cmd(ev_cmd), .to_virt(ev_virt), .phys_evt(phys_evt), .virt_evt(virt_evt));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == CYCLE_LIMIT)
        begin
            failures++;
            close_out();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    // Bitmap index 0..3 (phys g0, phys g1, virt g0, virt g1), or -1 when refused
    function automatic int target(input icap_pkg::icap_req_type q, input logic [1:0] rt);
        logic ns1;
        ns1 = q.nonsecure && q.el == icap_pkg::ICAP_EL1;
        case (q.cls)
            icap_pkg::ICAP_CLS_PHYS: return q.el == icap_pkg::ICAP_EL0 ? -1 : (ns1 && rt[q.grp] ? 2 : 0) + int'(q.grp);
            icap_pkg::ICAP_CLS_VIRT: return ns1 ? 2 + int'(q.grp) : -1;
            default: return q.el >= icap_pkg::ICAP_EL2 ? 2 + int'(q.grp) : -1;
        endcase
    endfunction : target

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Checks what the access of two calls ago left, then drives a new one
    task automatic op(input icap_pkg::icap_req_type q, input icap_pkg::icap_evt_type ev, input logic v,
        input logic [1:0] rt);
        int t;
        @(posedge clk_sys);
        check("rsp", rsp, e_rsp[1]);
        for (int k = 0; k < 4; k++)
            check("bitmap", {2'b00, ap[k]}, {2'b00, e_ap[1][k]});
        t = q.valid ? target(q, rt) : -1;
        e_rsp[1] = e_rsp[0];
        e_ap[1] = e_ap[0];
        e_rsp[0] = {q.valid, q.valid && t < 0, (t >= 0 && !q.write) ? exp_ap[t] : 32'h0};
        if (t >= 0 && q.write)
            exp_ap[t] = q.wdata;
        if (ev.valid)
            exp_ap[(v ? 2 : 0) + int'(ev.grp)][ev.prio[7:3]] = ev.activate;
        e_ap[0] = exp_ap;
        req <= q;
        ev_cmd <= ev;
        ev_virt <= v;
        route <= rt;
    endtask : op

    task automatic rst();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        req <= '0;
        ev_cmd <= '0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        exp_ap = '{default: '0};
        e_rsp = '{default: '0};
        e_ap = '{default: '{default: '0}};
    endtask : rst

    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Corner cases: both routes, a clear route, 64-bit then 32-bit view, edge priorities
        r = '0;
        r.valid = 1'b1;
        r.write = 1'b1;
        r.el = icap_pkg::ICAP_EL1;
        r.nonsecure = 1'b1;
        r.wdata = 32'h5a5a_0f0f;
        op(r, '0, 1'b0, 2'b01);
        r.grp = icap_pkg::ICAP_GRP1;
        op(r, '0, 1'b0, 2'b10);
        r.grp = icap_pkg::ICAP_GRP0;
        r.wdata = 32'h0f0f_a5a5;
        op(r, '0, 1'b0, 2'b10);
        r.el = icap_pkg::ICAP_EL3;
        r.nonsecure = 1'b0;
        r.wide64 = 1'b1;
        r.wdata = 32'hc3c3_1234;
        op(r, '0, 1'b0, 2'b00);
        r.write = 1'b0;
        r.wide64 = 1'b0;
        op(r, '0, 1'b0, 2'b00);
        e = '0;
        e.valid = 1'b1;
        e.activate = 1'b1;
        e.prio = 8'hf8;
        op('0, e, 1'b0, 2'b00);
        e.prio = 8'h07;
        op('0, e, 1'b0, 2'b00);
        for (int n = 0; n < 400; n++)
        begin
            seed = xs(seed);
            r.valid = seed[0] | seed[1];
            r.write = seed[2];
            r.cls = icap_pkg::icap_class_type'(seed[4:3] % 2'd3);
            r.grp = icap_pkg::icap_grp_type'(seed[5]);
            r.el = icap_pkg::icap_el_type'(seed[7:6]);
            r.nonsecure = seed[8];
            r.wide64 = seed[9];
            seed = xs(seed);
            r.wdata = seed;
            seed = xs(seed);
            // No event beside a read, where read-versus-update order is left open
            e.valid = seed[0] && !(r.valid && !r.write);
            e.activate = seed[1];
            e.grp = icap_pkg::icap_grp_type'(seed[2]);
            e.prio = seed[3] ? seed[15:8] : (seed[4] ? 8'hf8 : 8'h07);
            op(r, e, seed[5], seed[7:6]);
            if (n == 200)
                rst();
        end
        repeat (2) op('0, '0, 1'b0, 2'b00);
        close_out();
    end
endmodule : irq_cpu_if_active_priority_bench
`default_nettype wire
